//--- include/rspc_defines.vh
// Purpose: constants for the reset and power-mode controller
// Assumes: 50 MHz reference clock
// Notes: offsets are register addresses on the plain port
`ifndef RSPC_DEFINES_VH
`define RSPC_DEFINES_VH
// ==========================================
// Register offsets
`define RSPC_ADDR_PMC 8'h87
`define RSPC_ADDR_RCR 8'hEF
`define RSPC_ADDR_SMC 8'hFF
// ==========================================
// Field positions
`define RSPC_PMC_IDLE 0
`define RSPC_PMC_STOP 1
`define RSPC_PMC_FLAG_LO 2
`define RSPC_RCR_PIN 0
`define RSPC_RCR_POR 1
`define RSPC_RCR_SW 4
`define RSPC_SMC_EN 7
`define RSPC_SMC_STAT 6
// ==========================================
// Reset values
`define RSPC_PMC_RESET 6'h00
`define RSPC_PORT_RESET 8'hFF
`define RSPC_RDATA_IDLE 8'h00
// ==========================================
// Timing
`define RSPC_CLK_KHZ 50000
`define RSPC_POR_DELAY_US 300
`define RSPC_WDT_DIV 12
`endif

//--- hdl/rspc_delay.v
// Purpose: power-on release delay counter
// Assumes: one clock, synchronous reset
// Notes: done is a level that stays until restart
`timescale 1ns/1ps
`default_nettype none
module rspc_delay #(
  parameter CYCLES = 15000,
  parameter W = 16
) (
  input wire ref_clk_i,
  input wire reset_i,
  input wire restart_i,
  input wire run_i,
  output reg done_o
);
  reg [W-1:0] cnt_r;

  // ==========================================
  // Counter
  always @(posedge ref_clk_i) begin
    if (reset_i || restart_i) begin
      cnt_r <= {W{1'b0}};
      done_o <= 1'b0;
    end else if (run_i && !done_o) begin
      if (cnt_r == CYCLES[W-1:0] - 1'b1) begin
        done_o <= 1'b1;
      end
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- hdl/rspc_div.v
// Purpose: clock divider giving a one-cycle enable pulse
// Assumes: one clock, synchronous reset
// Notes: restarting aligns the first tick to the restart
`timescale 1ns/1ps
`default_nettype none
module rspc_div #(
  parameter DIV = 12,
  parameter W = 4
) (
  input wire ref_clk_i,
  input wire reset_i,
  input wire run_i,
  output reg tick_o
);
  reg [W-1:0] cnt_r;

  // ==========================================
  // Divider
  always @(posedge ref_clk_i) begin
    if (reset_i || !run_i) begin
      cnt_r <= {W{1'b0}};
      tick_o <= 1'b0;
    end else if (cnt_r == DIV[W-1:0] - 1'b1) begin
      cnt_r <= {W{1'b0}};
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- hdl/rspc_top.v
// Purpose: reset sequencing, power modes and reset-cause flags
// Assumes: all inputs synchronous to ref_clk_i
// Notes: reset_i stands for the power-on event itself
//
// Chosen here: the plain strobed port.
`include "rspc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module rspc_top #(
  parameter POR_DELAY_US = `RSPC_POR_DELAY_US,
  parameter POR_DELAY_CYC = (POR_DELAY_US * `RSPC_CLK_KHZ) / 1000,
  parameter DLY_W = 16
) (
  input wire ref_clk_i,
  input wire reset_i,
  input wire supply_ok_i,
  input wire pin_reset_n_i,
  input wire other_reset_i,
  input wire irq_pending_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  output reg core_reset_o,
  output reg rst_pin_o,
  output reg rst_pin_oe_o,
  output reg cpu_clk_en_o,
  output reg periph_clk_en_o,
  output reg osc_en_o,
  output reg port_force_o,
  output reg [7:0] port_latch_o,
  output reg port_open_drain_o,
  output reg weak_pullup_en_o,
  output reg reset_exit_o,
  output reg clk_sel_int_o,
  output reg wdt_en_o,
  output reg wdt_tick_o
);
  // ==========================================
  // States
  localparam S_PORH = 3'd0;
  localparam S_PORD = 3'd1;
  localparam S_MONH = 3'd2;
  localparam S_EXTH = 3'd3;
  localparam S_RUN = 3'd4;
  localparam S_IDLE = 3'd5;
  localparam S_STOP = 3'd6;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [5:0] sw_flags_r;
  reg mon_en_r;
  reg mon_sel_r;
  reg por_flag_r;
  reg pin_flag_r;
  reg sw_flag_r;
  reg pin_cause_r;
  reg sw_cause_r;
  reg sw_req_r;
  wire dly_done;
  wire div_tick;
  wire mon_trip;
  wire ext_trip;
  wire pmc_wr;
  wire rcr_wr;
  wire smc_wr;
  wire in_reset_nxt;

  function is_reset_state;
    input [2:0] s;
    begin
      is_reset_state = (s == S_PORH) || (s == S_PORD) ||
                       (s == S_MONH) || (s == S_EXTH);
    end
  endfunction

  // ==========================================
  // Decode
  assign pmc_wr = wr_i && (addr_i == `RSPC_ADDR_PMC);
  assign rcr_wr = wr_i && (addr_i == `RSPC_ADDR_RCR);
  assign smc_wr = wr_i && (addr_i == `RSPC_ADDR_SMC);
  // Enabled alone is not enough; selection gates the trip
  assign mon_trip = mon_en_r && mon_sel_r && !supply_ok_i;
  assign ext_trip = !pin_reset_n_i || other_reset_i || sw_req_r;

  // ==========================================
  // Release delay
  rspc_delay #(
    .CYCLES(POR_DELAY_CYC),
    .W(DLY_W)
  ) u_delay (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .restart_i(!supply_ok_i || state_r != S_PORD),
    .run_i(state_r == S_PORD),
    .done_o(dly_done)
  );

  // ==========================================
  // Watchdog clock divider
  rspc_div #(
    .DIV(`RSPC_WDT_DIV),
    .W(4)
  ) u_div (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .run_i(wdt_en_o && state_r != S_STOP),
    .tick_o(div_tick)
  );

  // ==========================================
  // Sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_PORH: begin
        if (supply_ok_i) begin
          state_nxt = S_PORD;
        end
      end
      S_PORD: begin
        if (!supply_ok_i) begin
          state_nxt = S_PORH;
        end else if (dly_done && pin_reset_n_i && !other_reset_i) begin
          state_nxt = S_RUN;
        end
      end
      S_MONH: begin
        // No extra delay once supply is back
        if (supply_ok_i && pin_reset_n_i && !other_reset_i) begin
          state_nxt = S_RUN;
        end
      end
      S_EXTH: begin
        if (mon_trip) begin
          state_nxt = S_MONH;
        end else if (pin_reset_n_i && !other_reset_i) begin
          state_nxt = S_RUN;
        end
      end
      S_RUN: begin
        if (mon_trip) begin
          state_nxt = S_MONH;
        end else if (ext_trip) begin
          state_nxt = S_EXTH;
        end else if (pmc_wr && wdata_i[`RSPC_PMC_STOP]) begin
          state_nxt = S_STOP;
        end else if (pmc_wr && wdata_i[`RSPC_PMC_IDLE]) begin
          state_nxt = S_IDLE;
        end
      end
      S_IDLE: begin
        if (mon_trip) begin
          state_nxt = S_MONH;
        end else if (ext_trip) begin
          state_nxt = S_EXTH;
        end else if (irq_pending_i) begin
          state_nxt = S_RUN;
        end
      end
      S_STOP: begin
        // Interrupts are ignored here on purpose
        if (mon_trip) begin
          state_nxt = S_MONH;
        end else if (!pin_reset_n_i || other_reset_i) begin
          state_nxt = S_EXTH;
        end
      end
      default: begin
        state_nxt = S_PORH;
      end
    endcase
  end

  assign in_reset_nxt = is_reset_state(state_nxt);

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_r <= S_PORH;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================
  // Registers and flags
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      sw_flags_r <= `RSPC_PMC_RESET;
      mon_en_r <= 1'b1;
      mon_sel_r <= 1'b1;
      por_flag_r <= 1'b0;
      pin_flag_r <= 1'b0;
      sw_flag_r <= 1'b0;
      pin_cause_r <= 1'b0;
      sw_cause_r <= 1'b0;
      sw_req_r <= 1'b0;
    end else begin
      sw_req_r <= 1'b0;
      if (pmc_wr) begin
        sw_flags_r <= wdata_i[7:`RSPC_PMC_FLAG_LO];
      end
      if (smc_wr) begin
        mon_en_r <= wdata_i[`RSPC_SMC_EN];
      end
      if (rcr_wr) begin
        // Writing one selects the monitor as a reset source
        mon_sel_r <= wdata_i[`RSPC_RCR_POR];
        sw_req_r <= wdata_i[`RSPC_RCR_SW];
      end
      if (state_r == S_RUN || state_r == S_IDLE || state_r == S_STOP) begin
        pin_cause_r <= !pin_reset_n_i;
        sw_cause_r <= sw_req_r;
      end else if (state_r == S_EXTH && !pin_reset_n_i) begin
        pin_cause_r <= 1'b1;
      end
      if (is_reset_state(state_r) && !in_reset_nxt) begin
        if (state_r == S_EXTH) begin
          por_flag_r <= 1'b0;
          pin_flag_r <= pin_cause_r;
          sw_flag_r <= sw_cause_r;
        end else begin
          por_flag_r <= 1'b1;
          pin_flag_r <= 1'b0;
          sw_flag_r <= 1'b0;
        end
      end
      // Every reset state restores the PMC flag defaults; monitor enable and select keep their values
      if (in_reset_nxt) begin
        sw_flags_r <= `RSPC_PMC_RESET;
      end
    end
  end

  // ==========================================
  // Read port
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_o <= `RSPC_RDATA_IDLE;
    end else if (rd_i) begin
      case (addr_i)
        `RSPC_ADDR_PMC: rdata_o <= {sw_flags_r, 2'b00};
        `RSPC_ADDR_RCR: rdata_o <= {3'b000, sw_flag_r, 2'b00,
                                    por_flag_r, pin_flag_r};
        `RSPC_ADDR_SMC: rdata_o <= {mon_en_r, supply_ok_i, 6'b000000};
        default: rdata_o <= `RSPC_RDATA_IDLE;
      endcase
    end else begin
      rdata_o <= `RSPC_RDATA_IDLE;
    end
  end

  // ==========================================
  // Outputs
  // Data memory has no clear path; the core reset only restores
  // registers such as the stack pointer.
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      core_reset_o <= 1'b1;
      rst_pin_o <= 1'b0;
      rst_pin_oe_o <= 1'b1;
      cpu_clk_en_o <= 1'b0;
      periph_clk_en_o <= 1'b0;
      osc_en_o <= 1'b1;
      port_force_o <= 1'b1;
      port_latch_o <= `RSPC_PORT_RESET;
      port_open_drain_o <= 1'b1;
      weak_pullup_en_o <= 1'b1;
      reset_exit_o <= 1'b0;
      clk_sel_int_o <= 1'b1;
      wdt_en_o <= 1'b0;
      wdt_tick_o <= 1'b0;
    end else begin
      core_reset_o <= in_reset_nxt;
      rst_pin_o <= 1'b0;
      rst_pin_oe_o <= (state_nxt == S_PORH) || (state_nxt == S_PORD) ||
                      (state_nxt == S_MONH);
      cpu_clk_en_o <= (state_nxt == S_RUN);
      periph_clk_en_o <= (state_nxt == S_RUN) || (state_nxt == S_IDLE);
      osc_en_o <= (state_nxt != S_STOP);
      port_force_o <= in_reset_nxt;
      port_latch_o <= `RSPC_PORT_RESET;
      port_open_drain_o <= 1'b1;
      weak_pullup_en_o <= 1'b1;
      reset_exit_o <= is_reset_state(state_r) && !in_reset_nxt;
      if (in_reset_nxt) begin
        clk_sel_int_o <= 1'b1;
        wdt_en_o <= 1'b0;
      end else if (is_reset_state(state_r)) begin
        wdt_en_o <= 1'b1;
      end
      wdt_tick_o <= div_tick;
    end
  end
endmodule
`default_nettype wire

//--- bench/rspc_chk.sv
// Purpose: port-level checks for rspc_top
// Assumes: one clock, reset_i synchronous active high
// Notes: all checks sleep while reset_i is high
`include "rspc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module rspc_chk (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic supply_ok_i,
  input wire logic pin_reset_n_i,
  input wire logic other_reset_i,
  input wire logic irq_pending_i,
  input wire logic [7:0] addr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic core_reset_o,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_o,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic osc_en_o,
  input wire logic port_force_o,
  input wire logic [7:0] port_latch_o,
  input wire logic port_open_drain_o,
  input wire logic weak_pullup_en_o,
  input wire logic reset_exit_o,
  input wire logic clk_sel_int_o,
  input wire logic wdt_en_o
);
  // ==========================================
  // Assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  chk_port_state: assert property (port_latch_o == `RSPC_PORT_RESET
    && port_open_drain_o && weak_pullup_en_o) else $error("port reset state lost");
  chk_reset_halt: assert property (core_reset_o |-> port_force_o && !cpu_clk_en_o
    && !periph_clk_en_o && !wdt_en_o) else $error("core not halted in reset");
  chk_pin_drive: assert property (rst_pin_oe_o |-> core_reset_o && !rst_pin_o)
    else $error("reset pin driven outside reset");
  chk_exit_pulse: assert property ($fell(core_reset_o) |-> reset_exit_o ##1 !reset_exit_o)
    else $error("bad reset exit pulse");
  chk_exit_state: assert property (reset_exit_o |-> wdt_en_o && clk_sel_int_o)
    else $error("exit state wrong");
  chk_read_flags: assert property ($past(rd_i) && $past(addr_i) == `RSPC_ADDR_PMC
    |-> rdata_o[1:0] == 2'b00) else $error("mode bits read nonzero");
  chk_stop_hold: assert property (!osc_en_o && !core_reset_o && pin_reset_n_i
    && !other_reset_i && supply_ok_i |=> !osc_en_o) else $error("stop left without reset");
  chk_idle_wake: assert property (!cpu_clk_en_o && periph_clk_en_o && irq_pending_i
    && pin_reset_n_i && !other_reset_i && supply_ok_i |-> ##[1:2] cpu_clk_en_o)
    else $error("idle not woken");
  chk_idle_periph: assert property (!cpu_clk_en_o && osc_en_o && !core_reset_o
    |-> periph_clk_en_o) else $error("peripheral clock lost in idle");
  chk_ext_trip: assert property (!pin_reset_n_i |=> core_reset_o)
    else $error("pin reset not taken");
  cov_idle: cover property (!cpu_clk_en_o && periph_clk_en_o);
  cov_stop: cover property (!osc_en_o && !core_reset_o);
  cov_pin_drive: cover property (rst_pin_oe_o && supply_ok_i);
endmodule
bind rspc_top rspc_chk u_rspc_chk (.ref_clk_i, .reset_i, .supply_ok_i, .pin_reset_n_i,
  .other_reset_i, .irq_pending_i, .addr_i, .rd_i, .rdata_o, .core_reset_o, .rst_pin_o,
  .rst_pin_oe_o, .cpu_clk_en_o, .periph_clk_en_o, .osc_en_o, .port_force_o, .port_latch_o,
  .port_open_drain_o, .weak_pullup_en_o, .reset_exit_o, .clk_sel_int_o, .wdt_en_o);
`default_nettype wire

//--- bench/tb.sv
// Purpose: directed bench for rspc_top
// Assumes: 50 MHz clock, short power-on delay
// Notes: delay shortened so the run stays brief
`include "rspc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================
  // Wiring
  localparam int DLY = 8;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic supply_ok_i = 1'b1;
  logic pin_reset_n_i = 1'b1;
  logic other_reset_i = 1'b0;
  logic irq_pending_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  wire [7:0] rdata_o, port_latch_o;
  wire core_reset_o, rst_pin_o, rst_pin_oe_o, cpu_clk_en_o, periph_clk_en_o, osc_en_o;
  wire port_force_o, port_open_drain_o, weak_pullup_en_o, reset_exit_o;
  wire clk_sel_int_o, wdt_en_o, wdt_tick_o;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  rspc_top #(.POR_DELAY_CYC(DLY)) u_rspc_top (.ref_clk_i, .reset_i, .supply_ok_i,
    .pin_reset_n_i, .other_reset_i, .irq_pending_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .core_reset_o, .rst_pin_o, .rst_pin_oe_o, .cpu_clk_en_o, .periph_clk_en_o,
    .osc_en_o, .port_force_o, .port_latch_o, .port_open_drain_o, .weak_pullup_en_o,
    .reset_exit_o, .clk_sel_int_o, .wdt_en_o, .wdt_tick_o);
  always #10 ref_clk_i = ~ref_clk_i;
  // A hang costs a mismatch rather than an endless run
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      results();
    end
  end
  // ==========================================
  // Tasks
  task automatic step();
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o & m, e);
  endtask
  task automatic wait_rel();
    n = 0;
    while (core_reset_o !== 1'b0 && n < 400) begin
      step();
      n++;
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (16) step();
    check({6'h0, core_reset_o, rst_pin_oe_o}, 8'h03);
    check(port_latch_o, `RSPC_PORT_RESET);
    check({5'h0, port_force_o, port_open_drain_o, weak_pullup_en_o}, 8'h07);
    reset_i <= 1'b0;
    wait_rel();
    check(8'(n >= DLY), 8'h01);
    check({5'h0, wdt_en_o, clk_sel_int_o, reset_exit_o}, 8'h07);
    $display("done: power-on");
    rdc(`RSPC_ADDR_PMC, 8'hFF, 8'h00);
    wr(`RSPC_ADDR_PMC, 8'hFC);
    rdc(`RSPC_ADDR_PMC, 8'hFF, 8'hFC);
    rdc(`RSPC_ADDR_RCR, 8'h03, 8'h02);
    rdc(`RSPC_ADDR_SMC, 8'hFF, 8'hC0);
    rdc(8'h10, 8'hFF, 8'h00);
    n = 0;
    while (wdt_tick_o !== 1'b1 && n < 30) begin
      step();
      n++;
    end
    n = 0;
    do begin
      step();
      n++;
    end while (wdt_tick_o !== 1'b1 && n < 30);
    check(8'(n), 8'h0C);
    $display("done: registers");
    wr(`RSPC_ADDR_PMC, 8'h01);
    #1;
    check({5'h0, cpu_clk_en_o, periph_clk_en_o, osc_en_o}, 8'h03);
    irq_pending_i <= 1'b1;
    step();
    step();
    check({7'h0, cpu_clk_en_o}, 8'h01);
    irq_pending_i <= 1'b0;
    rdc(`RSPC_ADDR_PMC, 8'hFF, 8'h00);
    wr(`RSPC_ADDR_PMC, 8'hFE);
    #1;
    check({5'h0, cpu_clk_en_o, periph_clk_en_o, osc_en_o}, 8'h00);
    irq_pending_i <= 1'b1;
    repeat (6) step();
    check({7'h0, osc_en_o}, 8'h00);
    irq_pending_i <= 1'b0;
    pin_reset_n_i <= 1'b0;
    step();
    step();
    check({6'h0, core_reset_o, rst_pin_oe_o}, 8'h02);
    pin_reset_n_i <= 1'b1;
    wait_rel();
    rdc(`RSPC_ADDR_RCR, 8'h03, 8'h01);
    rdc(`RSPC_ADDR_PMC, 8'hFF, 8'h00);
    $display("done: power modes");
    supply_ok_i <= 1'b0;
    step();
    step();
    check({6'h0, core_reset_o, rst_pin_oe_o}, 8'h03);
    supply_ok_i <= 1'b1;
    wait_rel();
    check(8'(n), 8'h01);
    rdc(`RSPC_ADDR_RCR, 8'h02, 8'h02);
    wr(`RSPC_ADDR_SMC, 8'h00);
    wr(`RSPC_ADDR_RCR, 8'h10);
    repeat (3) step();
    wait_rel();
    rdc(`RSPC_ADDR_RCR, 8'h12, 8'h10);
    rdc(`RSPC_ADDR_SMC, 8'hFF, 8'h40);
    supply_ok_i <= 1'b0;
    repeat (3) step();
    check({7'h0, core_reset_o}, 8'h00);
    supply_ok_i <= 1'b1;
    wr(`RSPC_ADDR_SMC, 8'h80);
    supply_ok_i <= 1'b0;
    repeat (3) step();
    check({7'h0, core_reset_o}, 8'h00);
    supply_ok_i <= 1'b1;
    repeat (4) step();
    wr(`RSPC_ADDR_RCR, 8'h02);
    other_reset_i <= 1'b1;
    step();
    step();
    other_reset_i <= 1'b0;
    wait_rel();
    rdc(`RSPC_ADDR_RCR, 8'h02, 8'h00);
    supply_ok_i <= 1'b0;
    step();
    step();
    check({7'h0, core_reset_o}, 8'h01);
    supply_ok_i <= 1'b1;
    wait_rel();
    $display("done: monitor");
    wr(`RSPC_ADDR_SMC, 8'h00);
    reset_i <= 1'b1;
    supply_ok_i <= 1'b0;
    repeat (3) step();
    reset_i <= 1'b0;
    repeat (20) step();
    check({7'h0, core_reset_o}, 8'h01);
    supply_ok_i <= 1'b1;
    repeat (4) step();
    supply_ok_i <= 1'b0;
    step();
    supply_ok_i <= 1'b1;
    wait_rel();
    check(8'(n >= DLY), 8'h01);
    rdc(`RSPC_ADDR_SMC, 8'hFF, 8'hC0);
    rdc(`RSPC_ADDR_RCR, 8'h02, 8'h02);
    $display("done: supply ramp");
    results();
  end
endmodule
`default_nettype wire
